// >>> shared/bsav_defines.svh
`ifndef BSAV_DEFINES_SVH
`define BSAV_DEFINES_SVH

// ==========================================================
// register byte offsets on the apb side
`define BSAV_OFF_ADDR_SW 8'h00
`define BSAV_OFF_VEC_SW 8'h04
`define BSAV_OFF_CTRL 8'h08
`define BSAV_OFF_IRQ_STAT 8'h0c
`define BSAV_OFF_IRQ_CLR 8'h10
`define BSAV_OFF_IRQ_EN 8'h14
`define BSAV_OFF_BUS_STAT 8'h18
`define BSAV_OFF_BYTE_BASE 8'h20
`define BSAV_OFF_BYTE_LAST 8'h3c

// ==========================================================
// field positions
`define BSAV_CTRL_IE_IN 0
`define BSAV_CTRL_IE_OUT 1
`define BSAV_EV_IN_DONE 0
`define BSAV_EV_OUT_DONE 1
`define BSAV_EV_HOST_WR 2

// ==========================================================
// reset values
`define BSAV_ADDR_SW_RST 10'h000
`define BSAV_VEC_SW_RST 6'h00
`define BSAV_CTRL_RST 2'h0
`define BSAV_IRQ_EN_RST 3'h0

// ==========================================================
// host address decode and vector constants
`define BSAV_TOP_ADDR_ONES 5'h1f
`define BSAV_VEC_LOW_ZERO 2'h0
`define BSAV_VEC_DRIVE_MASK 9'h1fc

`endif

// >>> shared/bsav_pkg.sv
package bsav_pkg;

	// ==========================================================
	// vector delivery sequence
	typedef enum logic [3:0]
	{
		BSAV_IDLE = 4'b0001,
		BSAV_REQ = 4'b0010,
		BSAV_VEC = 4'b0100,
		BSAV_DONE = 4'b1000
	} bsav_vstate_t;

endpackage

// >>> shared/bsav_if.sv
`timescale 1ns/1ps

interface bsav_if;
	logic [17:0] addr;
	logic [9:0] addr_sw;
	logic match;
	logic [2:0] sel;
	logic [5:0] vec_sw;
	logic rdy_in;
	logic rdy_out;
	logic ie_in;
	logic ie_out;
	logic serve_out;
	logic req_in;
	logic req_out;
	logic [8:0] vector;

	modport decode (input addr, input addr_sw, output match, output sel);
	modport vgen (input vec_sw, input rdy_in, input rdy_out, input ie_in, input ie_out,
		input serve_out, output req_in, output req_out, output vector);
endinterface

// >>> rtl/bsav_addr_dec.sv
`timescale 1ns/1ps
`include "bsav_defines.svh"

module bsav_addr_decode
(
	bsav_if.decode bus // host address in, match and register select out
);
	logic [9:0] bit_ok;

	// ==========================================================
	// per-bit switch compare
	genvar g;
	generate
		for (g = 0; g < 10; g++)
		begin : g_cmp
			// closed switch wants a zero, open wants a one
			assign bit_ok[g] = bus.addr[g + 3] == ~bus.addr_sw[g];
		end
	endgenerate

	assign bus.match = (bus.addr[17:13] == `BSAV_TOP_ADDR_ONES) && (&bit_ok);
	assign bus.sel = bus.addr[2:0];
endmodule // bsav_addr_decode

// >>> rtl/bsav_vec_gen.sv
`timescale 1ns/1ps
`include "bsav_defines.svh"

module bsav_vec_gen
(
	bsav_if.vgen bus // flags and switches in, requests and vector out
);
	assign bus.req_in = bus.rdy_in & bus.ie_in;
	assign bus.req_out = bus.rdy_out & bus.ie_out;
	// bit 2 picks xx0 or xx4, so the two vectors sit four apart
	assign bus.vector = {bus.vec_sw, bus.serve_out, `BSAV_VEC_LOW_ZERO};
endmodule // bsav_vec_gen

// >>> rtl/bsav_top.sv
`timescale 1ns/1ps
`include "bsav_defines.svh"

module bsav_top
(
	input wire logic i_clk, // 200 mhz clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic i_pwrite, // apb direction
	input wire logic [7:0] i_paddr, // apb byte address
	input wire logic [31:0] i_pwdata, // apb write data
	output logic [31:0] o_prdata, // apb read data
	output logic o_pready, // apb ready
	output logic o_pslverr, // apb error on unmapped address
	input wire logic [17:0] i_hb_addr, // host bus address pins
	input wire logic [7:0] i_hb_data, // host bus data in
	input wire logic i_hb_msyn, // host master strobe
	input wire logic i_hb_write, // host cycle is a write
	output logic [7:0] o_hb_data, // host read data out
	output logic o_hb_data_oe, // host data driven
	output logic o_hb_ssyn, // slave reply strobe
	input wire logic i_rdy_in, // input-ready flag, same clock
	input wire logic i_rdy_out, // output_ready_signal, same clock
	input wire logic i_bus_grant, // interrupt grant pin
	output logic o_bus_request_level_five, // interrupt bus request
	output logic [8:0] o_vec_data, // vector data lines out
	output logic [8:0] o_vec_oe, // per-line vector enables
	output logic o_vec_intr, // vector is on the lines
	output logic o_irq // local interrupt, level
);
	localparam int SYNC_W = 29;

	// ==========================================================
	// state
	typedef struct packed
	{
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
		logic [9:0] addr_sw;
		logic [5:0] vec_sw;
		logic [1:0] ctrl;
		logic [2:0] irq_stat;
		logic [2:0] irq_en;
		logic [7:0][7:0] bytes;
		bsav_pkg::bsav_vstate_t vst;
		logic serve_out;
		logic hb_ssyn;
		logic [7:0] hb_data;
		logic hb_oe;
		logic [8:0] vec_data;
		logic [8:0] vec_oe;
		logic br;
		logic vintr;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} bsav_state_t;

	bsav_state_t st_reg;
	bsav_state_t st_next;

	logic [17:0] hb_addr_s;
	logic [7:0] hb_data_s;
	logic hb_msyn_s;
	logic hb_write_s;
	logic grant_s;

	// only the second stage is read
	assign hb_addr_s = st_reg.sync2[17:0];
	assign hb_data_s = st_reg.sync2[25:18];
	assign hb_msyn_s = st_reg.sync2[26];
	assign hb_write_s = st_reg.sync2[27];
	assign grant_s = st_reg.sync2[28];

	// ==========================================================
	// decode and vector submodules
	bsav_if bus ();

	assign bus.addr = hb_addr_s;
	assign bus.addr_sw = st_reg.addr_sw;
	assign bus.vec_sw = st_reg.vec_sw;
	assign bus.rdy_in = i_rdy_in;
	assign bus.rdy_out = i_rdy_out;
	assign bus.ie_in = st_reg.ctrl[`BSAV_CTRL_IE_IN];
	assign bus.ie_out = st_reg.ctrl[`BSAV_CTRL_IE_OUT];
	assign bus.serve_out = st_reg.serve_out;

	bsav_addr_decode u_decode
	(
		.bus(bus.decode)
	);

	bsav_vec_gen u_vgen
	(
		.bus(bus.vgen)
	);

	// ==========================================================
	// next state
	always_comb
	begin
		logic setup;
		logic access;
		logic [2:0] ev;
		logic [2:0] clr;
		logic [2:0] bidx;
		setup = 1'b0;
		access = 1'b0;
		ev = 3'h0;
		clr = 3'h0;
		bidx = 3'h0;

		st_next = st_reg;
		st_next.sync1 = {i_bus_grant, i_hb_write, i_hb_msyn, i_hb_data, i_hb_addr};
		st_next.sync2 = st_reg.sync1;

		// apb: data prepared in setup, ready in the first access cycle
		setup = i_psel & ~i_penable;
		access = i_psel & i_penable & st_reg.pready;
		bidx = i_paddr[4:2];
		st_next.pready = setup;
		// error flag only lives in the ready cycle, so the pin needs no gate
		st_next.pslverr = 1'b0;
		if (setup)
		begin
			st_next.prdata = 32'h0;
			st_next.pslverr = 1'b0;
			if (i_paddr >= `BSAV_OFF_BYTE_BASE && i_paddr <= `BSAV_OFF_BYTE_LAST
				&& i_paddr[1:0] == 2'h0)
			begin
				st_next.prdata = {24'h0, st_reg.bytes[bidx]};
			end
			else
			begin
				unique case (i_paddr)
					`BSAV_OFF_ADDR_SW: st_next.prdata = {22'h0, st_reg.addr_sw};
					`BSAV_OFF_VEC_SW: st_next.prdata = {26'h0, st_reg.vec_sw};
					`BSAV_OFF_CTRL: st_next.prdata = {30'h0, st_reg.ctrl};
					`BSAV_OFF_IRQ_STAT: st_next.prdata = {29'h0, st_reg.irq_stat};
					`BSAV_OFF_IRQ_CLR: st_next.prdata = 32'h0;
					`BSAV_OFF_IRQ_EN: st_next.prdata = {29'h0, st_reg.irq_en};
					`BSAV_OFF_BUS_STAT: st_next.prdata = {19'h0, st_reg.vec_data,
						st_reg.vst};
					default: st_next.pslverr = 1'b1;
				endcase
			end
		end
		else if (access)
		begin
			st_next.pready = 1'b0;
		end

		if (access && i_pwrite && !st_reg.pslverr)
		begin
			unique case (i_paddr)
				`BSAV_OFF_ADDR_SW: st_next.addr_sw = i_pwdata[9:0];
				`BSAV_OFF_VEC_SW: st_next.vec_sw = i_pwdata[5:0];
				`BSAV_OFF_CTRL: st_next.ctrl = i_pwdata[1:0];
				`BSAV_OFF_IRQ_CLR: clr = i_pwdata[2:0];
				`BSAV_OFF_IRQ_EN: st_next.irq_en = i_pwdata[2:0];
				default: clr = 3'h0;
			endcase
		end

		// host byte register access, one reply per strobe
		if (hb_msyn_s && bus.match && !st_reg.hb_ssyn)
		begin
			st_next.hb_ssyn = 1'b1;
			if (hb_write_s)
			begin
				st_next.bytes[bus.sel] = hb_data_s;
				ev[`BSAV_EV_HOST_WR] = 1'b1;
			end
			else
			begin
				st_next.hb_data = st_reg.bytes[bus.sel];
				st_next.hb_oe = 1'b1;
			end
		end
		else if (!hb_msyn_s)
		begin
			st_next.hb_ssyn = 1'b0;
			st_next.hb_oe = 1'b0;
			st_next.hb_data = 8'h0;
		end

		// interrupt request and vector delivery
		unique case (st_reg.vst)
			bsav_pkg::BSAV_IDLE:
			begin
				// input side is served first when both are pending
				if (bus.req_in || bus.req_out)
				begin
					st_next.serve_out = ~bus.req_in;
					st_next.br = 1'b1;
					st_next.vst = bsav_pkg::BSAV_REQ;
				end
			end
			bsav_pkg::BSAV_REQ:
			begin
				if (!(st_reg.serve_out ? bus.req_out : bus.req_in))
				begin
					// flag withdrawn before grant: drop the request
					st_next.br = 1'b0;
					st_next.vst = bsav_pkg::BSAV_IDLE;
				end
				else if (grant_s)
				begin
					st_next.br = 1'b0;
					st_next.vec_data = bus.vector;
					st_next.vec_oe = `BSAV_VEC_DRIVE_MASK;
					st_next.vintr = 1'b1;
					st_next.vst = bsav_pkg::BSAV_VEC;
				end
			end
			bsav_pkg::BSAV_VEC:
			begin
				if (!grant_s)
				begin
					// host has taken the vector once grant falls
					st_next.vec_data = 9'h0;
					st_next.vec_oe = 9'h0;
					st_next.vintr = 1'b0;
					st_next.vst = bsav_pkg::BSAV_DONE;
					if (st_reg.serve_out)
					begin
						ev[`BSAV_EV_OUT_DONE] = 1'b1;
					end
					else
					begin
						ev[`BSAV_EV_IN_DONE] = 1'b1;
					end
				end
			end
			bsav_pkg::BSAV_DONE:
			begin
				// one idle cycle lets the served flag drop first
				st_next.vst = bsav_pkg::BSAV_IDLE;
			end
			default:
			begin
				st_next.br = 1'b0;
				st_next.vec_oe = 9'h0;
				st_next.vintr = 1'b0;
				st_next.vst = bsav_pkg::BSAV_IDLE;
			end
		endcase

		// set wins over a clear in the same cycle
		st_next.irq_stat = (st_reg.irq_stat & ~clr) | ev;
		st_next.irq = |(st_next.irq_stat & st_next.irq_en);
	end

	// ==========================================================
	// registers
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_reg.sync1 <= '0;
			st_reg.sync2 <= '0;
			st_reg.addr_sw <= `BSAV_ADDR_SW_RST;
			st_reg.vec_sw <= `BSAV_VEC_SW_RST;
			st_reg.ctrl <= `BSAV_CTRL_RST;
			st_reg.irq_stat <= 3'h0;
			st_reg.irq_en <= `BSAV_IRQ_EN_RST;
			st_reg.bytes <= '0;
			st_reg.vst <= bsav_pkg::BSAV_IDLE;
			st_reg.serve_out <= 1'b0;
			st_reg.hb_ssyn <= 1'b0;
			st_reg.hb_data <= 8'h0;
			st_reg.hb_oe <= 1'b0;
			st_reg.vec_data <= 9'h0;
			st_reg.vec_oe <= 9'h0;
			st_reg.br <= 1'b0;
			st_reg.vintr <= 1'b0;
			st_reg.prdata <= 32'h0;
			st_reg.pready <= 1'b0;
			st_reg.pslverr <= 1'b0;
			st_reg.irq <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs, all straight from flops
	assign o_prdata = st_reg.prdata;
	assign o_pready = st_reg.pready;
	assign o_pslverr = st_reg.pslverr;
	assign o_hb_data = st_reg.hb_data;
	assign o_hb_data_oe = st_reg.hb_oe;
	assign o_hb_ssyn = st_reg.hb_ssyn;
	assign o_bus_request_level_five = st_reg.br;
	assign o_vec_data = st_reg.vec_data;
	assign o_vec_oe = st_reg.vec_oe;
	assign o_vec_intr = st_reg.vintr;
	assign o_irq = st_reg.irq;
endmodule // bsav_top

// >>> tb/bsav_chk.sv
`timescale 1ns/1ps
// ==========================================================
// port checks, bound to the top
module bsav_chk
(
	input wire logic i_clk, // clock
	input wire logic i_rst_n, // reset
	input wire logic i_psel, // apb
	input wire logic i_penable, // apb
	input wire logic o_pready, // apb
	input wire logic o_pslverr, // apb
	input wire logic [17:0] i_hb_addr, // host address
	input wire logic o_hb_ssyn, // host reply
	input wire logic i_rdy_in, // flag
	input wire logic i_rdy_out, // flag
	input wire logic i_bus_grant, // grant
	input wire logic o_bus_request_level_five, // request
	input wire logic [8:0] o_vec_data, // vector
	input wire logic [8:0] o_vec_oe, // enables
	input wire logic o_vec_intr // vector on
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_vec_up;
		$rose(o_vec_intr);
	endsequence
	AST_APB_ACC: assert property (o_pready |-> i_psel && i_penable
		&& $past(i_psel && !i_penable)) else $error("ready outside access");
	AST_ERR_RDY: assert property (o_pslverr |-> o_pready) else $error("lone slverr");
	AST_TOP_ONES: assert property (o_hb_ssyn |-> i_hb_addr[17:13] == 5'h1f)
		else $error("reply outside top region");
	AST_LOW_ZERO: assert property (o_vec_intr |-> o_vec_data[1:0] == 2'h0)
		else $error("vector low bits set");
	AST_OE_MASK: assert property (o_vec_intr |-> o_vec_oe == 9'h1fc)
		else $error("vector enables wrong");
	AST_BIT2: assert property (s_vec_up |-> (o_vec_data[2] ? $past(i_rdy_out)
		: $past(i_rdy_in))) else $error("vector bit 2 wrong");
	AST_REQ_SRC: assert property ($rose(o_bus_request_level_five)
		|-> $past(i_rdy_in || i_rdy_out)) else $error("request without flag");
	AST_GRANT: assert property (s_vec_up |-> $past(i_bus_grant, 2)
		&& !o_bus_request_level_five) else $error("vector without grant");
	AST_RELEASE: assert property ($fell(i_bus_grant) |-> ##[1:4] !o_vec_intr
		&& o_vec_oe == 9'h000) else $error("vector not released");
endmodule // bsav_chk

bind bsav_top bsav_chk chk
(
	.i_clk(i_clk),
	.i_rst_n(i_rst_n),
	.i_psel(i_psel),
	.i_penable(i_penable),
	.o_pready(o_pready),
	.o_pslverr(o_pslverr),
	.i_hb_addr(i_hb_addr),
	.o_hb_ssyn(o_hb_ssyn),
	.i_rdy_in(i_rdy_in),
	.i_rdy_out(i_rdy_out),
	.i_bus_grant(i_bus_grant),
	.o_bus_request_level_five(o_bus_request_level_five),
	.o_vec_data(o_vec_data),
	.o_vec_oe(o_vec_oe),
	.o_vec_intr(o_vec_intr)
);

// >>> tb/bsav_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host processor: grants after a set wait, takes the vector
module bsav_host_model
(
	input wire logic i_clk, // clock
	input wire logic i_rst_n, // reset
	input wire logic [3:0] i_wait, // grant delay
	input wire logic i_req, // interrupt request
	input wire logic i_vec_intr, // vector on lines
	input wire logic [8:0] i_vec, // vector lines
	output logic o_grant, // interrupt grant
	output logic [8:0] o_vec, // last vector taken
	output int o_count // vectors taken
);
	logic [3:0] wait_cnt;
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_grant <= 1'b0;
			o_vec <= 9'h000;
			wait_cnt <= 4'h0;
			o_count <= 0;
		end
		else if (i_vec_intr && o_grant)
		begin
			o_vec <= i_vec;
			o_count <= o_count + 1;
			o_grant <= 1'b0;
		end
		else if (i_req && !o_grant)
		begin
			wait_cnt <= wait_cnt + 4'h1;
			if (wait_cnt >= i_wait)
				o_grant <= 1'b1;
		end
		else
			wait_cnt <= 4'h0;
	end
endmodule // bsav_host_model

// >>> tb/tb_bus_slave_address_and_vector_logic.sv
`timescale 1ns/1ps
module tb_bus_slave_address_and_vector_logic;
	logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_hb_msyn, i_hb_write;
	logic [7:0] i_paddr, i_hb_data, o_hb_data;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic [17:0] i_hb_addr;
	logic i_rdy_in, i_rdy_out, i_bus_grant, o_pready, o_pslverr, o_hb_data_oe, o_hb_ssyn;
	logic o_bus_request_level_five, o_vec_intr, o_irq, err;
	logic [8:0] o_vec_data, o_vec_oe, host_vec;
	logic [3:0] grant_wait;
	int fail_count, comparisons, host_count;
	localparam logic [17:0] HADDR = {5'h1f, 10'h00a, 3'h5};
	bsav_top dut
	(
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .i_hb_addr(i_hb_addr),
		.i_hb_data(i_hb_data), .i_hb_msyn(i_hb_msyn), .i_hb_write(i_hb_write),
		.o_hb_data(o_hb_data), .o_hb_data_oe(o_hb_data_oe), .o_hb_ssyn(o_hb_ssyn),
		.i_rdy_in(i_rdy_in), .i_rdy_out(i_rdy_out), .i_bus_grant(i_bus_grant),
		.o_bus_request_level_five(o_bus_request_level_five), .o_vec_data(o_vec_data),
		.o_vec_oe(o_vec_oe), .o_vec_intr(o_vec_intr), .o_irq(o_irq)
	);
	bsav_host_model host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wait(grant_wait),
		.i_req(o_bus_request_level_five), .i_vec_intr(o_vec_intr), .i_vec(o_vec_data),
		.o_grant(i_bus_grant), .o_vec(host_vec), .o_count(host_count));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		// no cycle limit here: only the watchdog ends a stuck wait
		do
			@(posedge i_clk);
		while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic hbus(input logic wr, input logic [17:0] a, input logic [7:0] d);
		int n;
		i_hb_addr <= a;
		i_hb_write <= wr;
		i_hb_data <= wr ? d : ~d;
		i_hb_msyn <= 1'b1;
		for (n = 0; o_hb_ssyn !== 1'b1 && n < 10; n++)
			@(posedge i_clk);
		rd = {23'h0, o_hb_data_oe, o_hb_data};
		err = o_hb_ssyn;
		i_hb_msyn <= 1'b0;
		for (n = 0; o_hb_ssyn !== 1'b0 && n < 10; n++)
			@(posedge i_clk);
		@(posedge i_clk);
	endtask
	task automatic irq_case(input logic ri, input logic ro, input int n, input logic [8:0] v);
		int c;
		c = host_count;
		i_rdy_in <= ri;
		i_rdy_out <= ro;
		repeat (30)
			if (host_count == c)
				@(posedge i_clk);
		i_rdy_in <= 1'b0;
		i_rdy_out <= 1'b0;
		repeat (10) @(posedge i_clk);
		check(host_count - c, n);
		if (n > 0)
			check(host_vec, v);
	endtask
	// ==========================================================
	// scenarios
	task automatic sc_host;
		apb(1'b1, 8'h00, 32'h3f5);
		apb(1'b0, 8'h00, 32'h0);
		check(rd, 32'h3f5);
		apb(1'b0, 8'h1c, 32'h0);
		check(err, 1'b1);
		apb(1'b1, 8'h14, 32'h4);
		hbus(1'b1, HADDR, 8'h5a);
		check(err, 1'b1);
		apb(1'b0, 8'h0c, 32'h0);
		check({rd[2], o_irq}, 2'h3);
		apb(1'b0, 8'h34, 32'h0);
		check(rd, 32'h5a);
		hbus(1'b0, HADDR, 8'h00);
		check(rd, 32'h15a);
		apb(1'b1, 8'h10, 32'h4);
		apb(1'b0, 8'h0c, 32'h0);
		check({rd[2], o_irq}, 2'h0);
		hbus(1'b0, HADDR & ~18'h02000, 8'h00);
		check(err, 1'b0);
		hbus(1'b0, HADDR ^ 18'h00008, 8'h00);
		check(err, 1'b0);
	endtask
	task automatic sc_irq;
		int c;
		apb(1'b1, 8'h04, 32'h2b);
		irq_case(1'b1, 1'b1, 0, 9'h000);
		apb(1'b1, 8'h08, 32'h3);
		irq_case(1'b1, 1'b0, 1, 9'h158);
		grant_wait <= 4'h6;
		irq_case(1'b0, 1'b1, 1, 9'h15c);
		irq_case(1'b1, 1'b1, 1, 9'h158);
		apb(1'b1, 8'h08, 32'h2);
		irq_case(1'b1, 1'b0, 0, 9'h000);
		// flag withdrawn before the grant: request must drop, no vector
		c = host_count;
		i_rdy_out <= 1'b1;
		repeat (3) @(posedge i_clk);
		check(o_bus_request_level_five, 1'b1);
		i_rdy_out <= 1'b0;
		repeat (20) @(posedge i_clk);
		check(o_bus_request_level_five, 1'b0);
		check(host_count - c, 0);
		apb(1'b0, 8'h0c, 32'h0);
		check(rd[1:0], 2'h3);
		apb(1'b0, 8'h18, 32'h0);
		check(rd, 32'h1);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	initial
	begin
		#50000;
		fail_count++;
		complete_run();
	end
	initial
	begin
		{i_rst_n, i_psel, i_penable, i_pwrite, i_hb_msyn, i_hb_write} = 6'h00;
		{i_paddr, i_hb_data, i_pwdata, i_hb_addr} = 66'h0;
		{i_rdy_in, i_rdy_out, grant_wait} = 6'h00;
		fail_count = 0;
		comparisons = 0;
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		sc_host();
		sc_irq();
		complete_run();
	end
endmodule // tb_bus_slave_address_and_vector_logic
